/* File: hdl/swr_defs.vh */
// Constants for the standby exit and reset initialisation block.
`ifndef SWR_DEFS_VH
`define SWR_DEFS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SWR_OFS_PIN_FUNCTION_CONTROL 8'h00
`define SWR_OFS_PERIPHERAL_ENABLE_SELECT 8'h04
`define SWR_OFS_SYSTEM_CONTROL 8'h08
`define SWR_OFS_DMA_REFRESH_WAIT_CYCLES 8'h0C
`define SWR_OFS_MEMORY_IO_WAIT_CYCLES 8'h10
`define SWR_OFS_MEMORY_BLOCK_SPLIT 8'h14
`define SWR_OFS_REFRESH_CONTROL 8'h18
`define SWR_OFS_STANDBY_CLOCK_CONTROL 8'h1C
`define SWR_OFS_TIMER_CLOCK_SELECT 8'h20
`define SWR_OFS_EXTENDED_SPACE_DIVISION 8'h24
`define SWR_OFS_SUB_MEMORY_BLOCK_SIZE 8'h28
`define SWR_OFS_IO_SUB_BLOCK_SIZE 8'h2C
`define SWR_OFS_SUB_BLOCK_WAIT_CYCLES 8'h30
`define SWR_OFS_BAUD_RATE_COUNTER 8'h34
`define SWR_OFS_INTERRUPT_MASK_WORD 8'h40
`define SWR_OFS_PSW 8'h44
`define SWR_OFS_STATUS 8'h48
`define SWR_OFS_PS_PC 8'h4C
`define SWR_OFS_SEGMENTS 8'h50
`define SWR_OFS_DATA_SEGMENTS 8'h54
`define SWR_NUM_SYSREG 14
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SWR_RST_PIN_FUNCTION_CONTROL 8'h00
`define SWR_RST_PERIPHERAL_ENABLE_SELECT 8'h00
`define SWR_RST_SYSTEM_CONTROL_NARROW 8'h01
`define SWR_RST_SYSTEM_CONTROL_WIDE 8'h00
`define SWR_RST_DMA_REFRESH_WAIT_CYCLES 8'hFF
`define SWR_RST_MEMORY_IO_WAIT_CYCLES 8'hFF
`define SWR_RST_MEMORY_BLOCK_SPLIT 8'h44
`define SWR_RST_REFRESH_CONTROL 8'h09
`define SWR_RST_STANDBY_CLOCK_CONTROL 8'h00
`define SWR_RST_TIMER_CLOCK_SELECT 8'h00
`define SWR_RST_EXTENDED_SPACE_DIVISION 8'h00
`define SWR_RST_SUB_MEMORY_BLOCK_SIZE 8'h00
`define SWR_RST_IO_SUB_BLOCK_SIZE 8'h00
`define SWR_RST_SUB_BLOCK_WAIT_CYCLES 8'hFF
`define SWR_RST_BAUD_RATE_COUNTER 8'h02
`define SWR_RST_INTERRUPT_MASK_WORD 8'hFF
`define SWR_RST_PROGRAM_SEGMENT 16'hFFFF
`define SWR_RST_PROGRAM_COUNTER 16'h0000
`define SWR_RST_SEGMENT 16'h0000
`define SWR_RST_PSW 16'hF002
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SWR_SBC_STOP_SEL 0
`define SWR_SBC_STAB_LO 1
`define SWR_SBC_STAB_HI 2
`define SWR_SBC_CLK_FULL 3
`define SWR_PSW_IE 9
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SWR_RESET_MIN_CLOCKS 3'd4
`define SWR_STAB_OSC_EXP 19
`define SWR_OSC_PER_CLK_DIV2 2
`endif

/* File: hdl/swr_stop_reset.v */
// Standby exit, reset qualification and reset value loading with an AHB-Lite slave.
// Behaviour
// - Halt with stop select set enters STOP.
// - Internal clock fully stopped during STOP.
// - Reset in STOP loads segment FFFFH, counter 0000H.
// - Unmasked maskable pin wakes STOP, services interrupt.
// - Pin held until acknowledge; early drop gives HALT.
// - Interrupts disabled: resume after halt, no service.
// - Masked pins never wake STOP.
// - High NMI wakes STOP, serviced after stabilisation.
// - NMI active at halt prevents STOP entry.
// - Reset needs at least five low clocks.
// - Prefetch starts at FFFF0H after reset.
// - Segments, queue and PSW loaded at reset.
// - Unlisted registers are not initialised.
// - Standby control resets to zero.
// - Three wait clocks on all cycle types.
// - Memory split into 512 KB blocks.
// - Refresh timer factor resets to nine.
// - Pin functions routed, peripherals disabled.
// - System control defaults, width by variant.
// - Timer channels clocked at internal over two.
// - No extended division, default sub-block sizes.
// - Sub-block waits three, baud counter 02H.
`include "swr_defs.vh"
module swr_stop_reset #(
   parameter BUS_WIDE = 0,
   parameter STAB_OSC_PERIODS = (1 << `SWR_STAB_OSC_EXP)
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg o_hreadyout,
   output reg [31:0] o_hrdata,
   output reg o_hresp,
   input wire i_reset_n,
   input wire i_halt_exec,
   input wire i_nmi,
   input wire [7:0] i_ext_maskable_irq_pin,
   input wire i_irq_ack,
   input wire i_nmi_vector_read,
   output reg o_cpu_clk_run,
   output reg o_periph_clk_run,
   output reg o_stop_mode,
   output reg o_halt_mode,
   output reg o_core_reset,
   output reg o_prefetch_start,
   output reg [19:0] o_prefetch_addr,
   output reg o_queue_clear,
   output reg o_irq_service,
   output reg o_nmi_service,
   output reg o_resume_after_halt
);
   localparam ST_RUN = 3'd0;
   localparam ST_HALT = 3'd1;
   localparam ST_STOP = 3'd2;
   localparam ST_STAB = 3'd3;
   localparam ST_IRQ_WAIT = 3'd4;
   localparam ST_NMI_WAIT = 3'd5;
   localparam ST_RESET = 3'd6;
   localparam [19:0] STAB_BASE = STAB_OSC_PERIODS[19:0];

   // ----------------------------------------------------------------------
   // Reset values of the system registers
   // ----------------------------------------------------------------------
   function [7:0] sys_rst_val;
      input [3:0] idx;
      begin
         case (idx)
            4'd0: sys_rst_val = `SWR_RST_PIN_FUNCTION_CONTROL;
            4'd1: sys_rst_val = `SWR_RST_PERIPHERAL_ENABLE_SELECT;
            4'd2: sys_rst_val = (BUS_WIDE != 0) ? `SWR_RST_SYSTEM_CONTROL_WIDE :
               `SWR_RST_SYSTEM_CONTROL_NARROW;
            4'd3: sys_rst_val = `SWR_RST_DMA_REFRESH_WAIT_CYCLES;
            4'd4: sys_rst_val = `SWR_RST_MEMORY_IO_WAIT_CYCLES;
            4'd5: sys_rst_val = `SWR_RST_MEMORY_BLOCK_SPLIT;
            4'd6: sys_rst_val = `SWR_RST_REFRESH_CONTROL;
            4'd7: sys_rst_val = `SWR_RST_STANDBY_CLOCK_CONTROL;
            4'd8: sys_rst_val = `SWR_RST_TIMER_CLOCK_SELECT;
            4'd9: sys_rst_val = `SWR_RST_EXTENDED_SPACE_DIVISION;
            4'd10: sys_rst_val = `SWR_RST_SUB_MEMORY_BLOCK_SIZE;
            4'd11: sys_rst_val = `SWR_RST_IO_SUB_BLOCK_SIZE;
            4'd12: sys_rst_val = `SWR_RST_SUB_BLOCK_WAIT_CYCLES;
            4'd13: sys_rst_val = `SWR_RST_BAUD_RATE_COUNTER;
            default: sys_rst_val = 8'h00;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg [7:0] sysreg [0:`SWR_NUM_SYSREG-1];
   reg [7:0] interrupt_mask_word;
   reg [15:0] program_segment;
   reg [15:0] program_counter;
   reg [15:0] prefetch_pointer;
   reg [15:0] stack_segment;
   reg [15:0] data_segment_0;
   reg [15:0] data_segment_1;
   reg [15:0] psw;
   reg [2:0] state;
   reg [2:0] rst_low_cnt;
   reg [19:0] stab_cnt;
   reg wake_by_nmi;
   reg wr_pend;
   reg [7:0] wr_addr;
   reg rd_pend;
   reg [7:0] rd_addr;
   integer i;

   wire [7:0] standby_clock_control = sysreg[7];
   wire [7:0] irq_unmasked = i_ext_maskable_irq_pin & ~interrupt_mask_word;
   wire irq_wake = |irq_unmasked;
   wire ie_flag = psw[`SWR_PSW_IE];
   wire rst_valid = (rst_low_cnt >= `SWR_RESET_MIN_CLOCKS);
   wire [1:0] stab_sel = standby_clock_control[`SWR_SBC_STAB_HI:`SWR_SBC_STAB_LO];
   wire [4:0] stab_shift = {2'b00, stab_sel, 1'b0} +
      (standby_clock_control[`SWR_SBC_CLK_FULL] ? 5'd0 : 5'd1);
   // Stabilisation counted in internal clocks: oscillator periods halved at f/2.
   wire [19:0] stab_load = STAB_BASE >> stab_shift;
   wire bus_take = i_hsel & i_htrans[1] & i_hready;
   wire [15:0] rst_ps = `SWR_RST_PROGRAM_SEGMENT;
   wire [15:0] rst_pc = `SWR_RST_PROGRAM_COUNTER;

   function [31:0] read_word;
      input [7:0] a;
      begin
         if (a < 8'h38 && a[1:0] == 2'b00) begin
            read_word = {24'h0000_00, sysreg[a[5:2]]};
         end else begin
            case (a)
               `SWR_OFS_INTERRUPT_MASK_WORD: read_word = {24'h0000_00, interrupt_mask_word};
               `SWR_OFS_PSW: read_word = {16'h0000, psw};
               `SWR_OFS_STATUS: read_word = {24'h0000_00, 2'b00, rst_low_cnt, state};
               `SWR_OFS_PS_PC: read_word = {program_segment, program_counter};
               `SWR_OFS_SEGMENTS: read_word = {stack_segment, prefetch_pointer};
               `SWR_OFS_DATA_SEGMENTS: read_word = {data_segment_1, data_segment_0};
               default: read_word = 32'h0000_0000;
            endcase
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // Bus slave and register file
   // ----------------------------------------------------------------------
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_hreadyout <= 1'b1;
         o_hrdata <= 32'h0000_0000;
         o_hresp <= 1'b0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_pend <= 1'b0;
         rd_addr <= 8'h00;
         interrupt_mask_word <= `SWR_RST_INTERRUPT_MASK_WORD;
         for (i = 0; i < `SWR_NUM_SYSREG; i = i + 1) begin
            sysreg[i] <= sys_rst_val(i[3:0]);
         end
      end else begin
         o_hresp <= 1'b0;
         wr_pend <= bus_take & i_hwrite & (i_haddr[31:8] == 24'h0000_00);
         wr_addr <= i_haddr[7:0];
         if (bus_take & ~i_hwrite) begin
            rd_pend <= 1'b1;
            rd_addr <= (i_haddr[31:8] == 24'h0000_00) ? i_haddr[7:0] : 8'hFF;
            o_hreadyout <= 1'b0;
         end else if (rd_pend) begin
            rd_pend <= 1'b0;
            o_hrdata <= read_word(rd_addr);
            o_hreadyout <= 1'b1;
         end
         if (state == ST_RESET) begin
            // Only the listed registers take fixed values; nothing else here is touched.
            for (i = 0; i < `SWR_NUM_SYSREG; i = i + 1) begin
               sysreg[i] <= sys_rst_val(i[3:0]);
            end
         end else if (wr_pend) begin
            if (wr_addr < 8'h38 && wr_addr[1:0] == 2'b00) begin
               sysreg[wr_addr[5:2]] <= i_hwdata[7:0];
            end else if (wr_addr == `SWR_OFS_INTERRUPT_MASK_WORD) begin
               interrupt_mask_word <= i_hwdata[7:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // CPU reset values
   // ----------------------------------------------------------------------
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         program_segment <= `SWR_RST_PROGRAM_SEGMENT;
         program_counter <= `SWR_RST_PROGRAM_COUNTER;
         prefetch_pointer <= `SWR_RST_SEGMENT;
         stack_segment <= `SWR_RST_SEGMENT;
         data_segment_0 <= `SWR_RST_SEGMENT;
         data_segment_1 <= `SWR_RST_SEGMENT;
         psw <= `SWR_RST_PSW;
      end else if (state == ST_RESET) begin
         program_segment <= `SWR_RST_PROGRAM_SEGMENT;
         program_counter <= `SWR_RST_PROGRAM_COUNTER;
         prefetch_pointer <= `SWR_RST_SEGMENT;
         stack_segment <= `SWR_RST_SEGMENT;
         data_segment_0 <= `SWR_RST_SEGMENT;
         data_segment_1 <= `SWR_RST_SEGMENT;
         psw <= `SWR_RST_PSW;
      end else if (wr_pend && wr_addr == `SWR_OFS_PSW) begin
         psw <= i_hwdata[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // Reset qualification and standby sequencer
   // ----------------------------------------------------------------------
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= ST_RUN;
         rst_low_cnt <= 3'd0;
         stab_cnt <= 20'h0_0000;
         wake_by_nmi <= 1'b0;
         o_core_reset <= 1'b0;
         o_prefetch_start <= 1'b0;
         o_prefetch_addr <= 20'h0_0000;
         o_queue_clear <= 1'b0;
         o_irq_service <= 1'b0;
         o_nmi_service <= 1'b0;
         o_resume_after_halt <= 1'b0;
      end else begin
         o_prefetch_start <= 1'b0;
         o_queue_clear <= 1'b0;
         o_irq_service <= 1'b0;
         o_nmi_service <= 1'b0;
         o_resume_after_halt <= 1'b0;
         if (~i_reset_n) begin
            if (~rst_valid) begin
               rst_low_cnt <= rst_low_cnt + 3'd1;
            end
         end else begin
            rst_low_cnt <= 3'd0;
         end
         if (~i_reset_n & rst_valid) begin
            // A qualified pulse overrides every standby state, STOP included.
            state <= ST_RESET;
            o_core_reset <= 1'b1;
         end else begin
            case (state)
               ST_RESET: begin
                  if (i_reset_n) begin
                     state <= ST_RUN;
                     o_core_reset <= 1'b0;
                     o_prefetch_start <= 1'b1;
                     o_prefetch_addr <= {rst_ps, 4'h0} + {4'h0, rst_pc};
                     o_queue_clear <= 1'b1;
                  end
               end
               ST_RUN: begin
                  if (i_halt_exec) begin
                     if (standby_clock_control[`SWR_SBC_STOP_SEL] & ~i_nmi) begin
                        state <= ST_STOP;
                     end else if (~standby_clock_control[`SWR_SBC_STOP_SEL]) begin
                        state <= ST_HALT;
                     end else begin
                        o_nmi_service <= 1'b1;
                     end
                  end
               end
               ST_HALT: begin
                  if (i_nmi) begin
                     state <= ST_RUN;
                     o_nmi_service <= 1'b1;
                  end else if (irq_wake) begin
                     state <= ST_RUN;
                     o_irq_service <= ie_flag;
                     o_resume_after_halt <= ~ie_flag;
                  end
               end
               ST_STOP: begin
                  if (i_nmi | irq_wake) begin
                     state <= ST_STAB;
                     wake_by_nmi <= i_nmi;
                     stab_cnt <= stab_load;
                  end
               end
               ST_STAB: begin
                  if (wake_by_nmi ? ~i_nmi : ~irq_wake) begin
                     // Source dropped during stabilisation: fall back to HALT.
                     state <= ST_HALT;
                  end else if (stab_cnt <= 20'h0_0001) begin
                     if (wake_by_nmi) begin
                        state <= ST_NMI_WAIT;
                        o_nmi_service <= 1'b1;
                     end else if (ie_flag) begin
                        state <= ST_IRQ_WAIT;
                        o_irq_service <= 1'b1;
                     end else begin
                        state <= ST_RUN;
                        o_resume_after_halt <= 1'b1;
                     end
                  end else begin
                     stab_cnt <= stab_cnt - 20'h0_0001;
                  end
               end
               ST_IRQ_WAIT: begin
                  if (i_irq_ack) begin
                     state <= ST_RUN;
                  end else if (~irq_wake) begin
                     state <= ST_HALT;
                  end
               end
               ST_NMI_WAIT: begin
                  if (i_nmi_vector_read) begin
                     state <= ST_RUN;
                  end else if (~i_nmi) begin
                     state <= ST_HALT;
                  end
               end
               default: state <= ST_RUN;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Clock run and standby indications, one cycle behind the state
   // ----------------------------------------------------------------------
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cpu_clk_run <= 1'b1;
         o_periph_clk_run <= 1'b1;
         o_stop_mode <= 1'b0;
         o_halt_mode <= 1'b0;
      end else begin
         // The oscillator is still settling during the wait, so no clock is given out yet.
         o_cpu_clk_run <= (state != ST_STOP) && (state != ST_STAB) && (state != ST_HALT);
         o_periph_clk_run <= (state != ST_STOP) && (state != ST_STAB);
         o_stop_mode <= (state == ST_STOP) || (state == ST_STAB);
         o_halt_mode <= (state == ST_HALT);
      end
   end
endmodule // swr_stop_reset

/* File: tb/swr_stop_reset_properties.sv */
// Port checks for the standby exit and reset block.
module swr_stop_reset_properties (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_hsel,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire i_hready,
   input wire o_hreadyout,
   input wire o_hresp,
   input wire i_reset_n,
   input wire i_halt_exec,
   input wire i_nmi,
   input wire [7:0] i_ext_maskable_irq_pin,
   input wire o_core_reset,
   input wire o_prefetch_start,
   input wire [19:0] o_prefetch_addr,
   input wire o_queue_clear,
   input wire o_irq_service,
   input wire o_nmi_service,
   input wire o_resume_after_halt,
   input wire o_cpu_clk_run,
   input wire o_periph_clk_run,
   input wire o_stop_mode
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire take = i_hsel && i_htrans[1] && i_hready;
   wire any_irq = |i_ext_maskable_irq_pin;
   property p_okay; !o_hresp; endproperty
   property p_rd_wait; take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout; endproperty
   property p_wr_nowait; take && i_hwrite |=> o_hreadyout; endproperty
   property p_rst_min;
      $rose(o_core_reset) |-> !$past(i_reset_n, 1) && !$past(i_reset_n, 2)
         && !$past(i_reset_n, 3) && !$past(i_reset_n, 4);
   endproperty
   property p_rst_hold; !i_reset_n [*6] |-> o_core_reset; endproperty
   property p_release;
      $fell(o_core_reset) |-> o_prefetch_start && o_queue_clear && o_prefetch_addr == 20'hF_FFF0;
   endproperty
   property p_pf_cause; o_prefetch_start |-> $past(o_core_reset); endproperty
   property p_nmi_halt; i_halt_exec && i_nmi |-> ##[1:3] o_nmi_service; endproperty
   property p_nmi_src; o_nmi_service |-> $past(i_nmi); endproperty
   property p_irq_src; o_irq_service |-> $past(any_irq) && !o_resume_after_halt; endproperty
   property p_clk_gate; o_stop_mode |-> !o_cpu_clk_run && !o_periph_clk_run; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
   a_rst_min: assert property (p_rst_min) else $error("reset taken too early");
   a_rst_hold: assert property (p_rst_hold) else $error("long reset not taken");
   a_release: assert property (p_release) else $error("bad prefetch on release");
   a_pf_cause: assert property (p_pf_cause) else $error("prefetch without reset");
   a_nmi_halt: assert property (p_nmi_halt) else $error("nmi at halt not served");
   a_nmi_src: assert property (p_nmi_src) else $error("nmi service without nmi");
   a_irq_src: assert property (p_irq_src) else $error("irq service without pin");
   a_clk_gate: assert property (p_clk_gate) else $error("clock runs in stop");
   c_read: cover property (take && !i_hwrite);
   c_reset: cover property ($fell(o_core_reset));
   c_irq: cover property (o_irq_service);
   c_nmi: cover property (o_nmi_service);
   c_stop: cover property (o_stop_mode);
endmodule // swr_stop_reset_properties

bind swr_stop_reset swr_stop_reset_properties u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_reset_n(i_reset_n),
   .i_halt_exec(i_halt_exec), .i_nmi(i_nmi), .i_ext_maskable_irq_pin(i_ext_maskable_irq_pin),
   .o_core_reset(o_core_reset), .o_prefetch_start(o_prefetch_start),
   .o_prefetch_addr(o_prefetch_addr), .o_queue_clear(o_queue_clear),
   .o_irq_service(o_irq_service), .o_nmi_service(o_nmi_service),
   .o_resume_after_halt(o_resume_after_halt), .o_cpu_clk_run(o_cpu_clk_run),
   .o_periph_clk_run(o_periph_clk_run), .o_stop_mode(o_stop_mode));

/* File: tb/swr_ext_src.sv */
// Model of the external reset and interrupt request sources.
module swr_ext_src (
   input wire logic i_clk,
   output logic o_reset_n,
   output logic o_nmi,
   output logic [7:0] o_irq_pins,
   output logic o_ack,
   output logic o_vec_read
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Line drivers
   // ----------------------------------------------------------------
   initial begin
      o_reset_n = 1'b1;
      o_nmi = 1'b0;
      o_irq_pins = 8'h00;
      o_ack = 1'b0;
      o_vec_read = 1'b0;
   end
   // Reset is held low for n whole clocks, as many as the caller asks for.
   task automatic pulse_reset(input int n);
      o_reset_n <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_reset_n <= 1'b1;
   endtask
   task automatic drive(input logic nmi, input logic [7:0] pins);
      o_nmi <= nmi;
      o_irq_pins <= pins;
      @(posedge i_clk);
   endtask
   // Lines stay up until the acknowledge or vector read, which may come late.
   task automatic answer(input logic vec, input int dly);
      repeat (dly) @(posedge i_clk);
      o_ack <= !vec;
      o_vec_read <= vec;
      @(posedge i_clk);
      o_ack <= 1'b0;
      o_vec_read <= 1'b0;
      o_nmi <= 1'b0;
      o_irq_pins <= 8'h00;
      @(posedge i_clk);
   endtask
endmodule // swr_ext_src

/* File: tb/testbench.sv */
// Self-checking bench for the standby exit and reset block.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_sys_rst, hsel, hwrite, halt;
   logic rd_ph = 1'b0;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, d;
   wire [31:0] hrdata;
   wire hready, hresp, reset_n, nmi, ack, vec, pf, qclr, irq_s, nmi_s, res_s, stp, hlt;
   wire [7:0] pins;
   wire [19:0] pf_addr;
   int err_count, checks;
   integer seed = 32'hd467;
   logic [31:0] q[$];
   logic [7:0] rv [14] = '{8'h00, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h44, 8'h09,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h02};
   logic [31:0] xa [7] = '{32'h40, 32'h44, 32'h4C, 32'h50, 32'h54, 32'h3C, 32'h100};
   logic [31:0] xe [7] = '{32'hFF, 32'hF002, 32'hFFFF_0000, 32'h0, 32'h0, 32'h0, 32'h0};
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   swr_stop_reset #(.BUS_WIDE(0), .STAB_OSC_PERIODS(64)) dut (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .i_reset_n(reset_n),
      .i_halt_exec(halt), .i_nmi(nmi), .i_ext_maskable_irq_pin(pins), .i_irq_ack(ack),
      .i_nmi_vector_read(vec), .o_cpu_clk_run(), .o_periph_clk_run(), .o_stop_mode(stp),
      .o_halt_mode(hlt), .o_core_reset(), .o_prefetch_start(pf), .o_prefetch_addr(pf_addr),
      .o_queue_clear(qclr), .o_irq_service(irq_s), .o_nmi_service(nmi_s),
      .o_resume_after_halt(res_s));
   swr_ext_src src (.i_clk(i_clk), .o_reset_n(reset_n), .o_nmi(nmi), .o_irq_pins(pins),
      .o_ack(ack), .o_vec_read(vec));
   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] nxt();
      if (q.size() == 0) return 32'hx;
      return q.pop_front();
   endfunction
   task automatic results;
      if (q.size() != 0) err_count++;
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Read data and every pulse are taken off the queue in the order they were noted.
   always @(posedge i_clk) begin
      if (rd_ph && hready === 1'b1) check(hrdata, nxt());
      if ({qclr, pf, irq_s, nmi_s, res_s} !== 5'h0) begin
         check({pf ? pf_addr : 20'h0, 7'h0, qclr, pf, irq_s, nmi_s, res_s}, nxt());
      end
      if (hready === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
   end
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge i_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge i_clk); while (hready !== 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic pin_reset;
      q.push_back(32'hFFFF_0018);
      src.pulse_reset(6);
      repeat (3) @(posedge i_clk);
   endtask
   task automatic halt_pulse;
      halt <= 1'b1;
      @(posedge i_clk);
      halt <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
   // Enters STOP, drives the given lines and checks the pulse and the final state.
   task automatic stop_case(input logic [7:0] sb, input logic [7:0] msk, input logic ie,
      input logic n, input logic [7:0] p, input logic drop, input logic [31:0] ep,
      input logic [31:0] st);
      int n_stab;
      n_stab = 64 >> (2 * sb[2:1]) >> (sb[3] ? 0 : 1);
      pin_reset();
      bus(1'b1, 32'h1C, {24'h0, sb});
      bus(1'b1, 32'h40, {24'h0, msk});
      bus(1'b1, 32'h44, ie ? 32'hF202 : 32'hF002);
      halt_pulse();
      rd(32'h48, 32'h2);
      check({30'h0, stp, hlt}, 32'h2);
      src.drive(n, p);
      repeat (drop ? 8 : n_stab - 4) @(posedge i_clk);
      if (drop) src.drive(1'b0, 8'h00);
      else if (ep != 0) q.push_back(ep);
      repeat (40) @(posedge i_clk);
      if (ep == 32'h4) src.answer(1'b0, 20);
      if (ep == 32'h2) src.answer(1'b1, 1);
      src.drive(1'b0, 8'h00);
      rd(32'h48, st);
      check({30'h0, stp, hlt}, {30'h0, st == 32'h2, st == 32'h1});
   endtask
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      {hsel, hwrite, halt, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      i_sys_rst = 1'b1;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      pin_reset();
      for (int i = 0; i < 14; i++) rd(32'(4 * i), {24'h0, rv[i]});
      bus(1'b1, 32'h3C, 32'($random(seed)));
      for (int i = 0; i < 7; i++) rd(xa[i], xe[i]);
      for (int i = 0; i < 14; i++) begin
         d = $random(seed);
         bus(1'b1, 32'(4 * i), d);
         rd(32'(4 * i), {24'h0, d[7:0]});
      end
      src.pulse_reset(3);
      repeat (4) @(posedge i_clk);
      rd(32'h34, {24'h0, d[7:0]});
      stop_case(8'h01, 8'h01, 1'b1, 1'b0, 8'h01, 1'b0, 32'h0, 32'h2);
      stop_case(8'h01, 8'h00, 1'b1, 1'b0, 8'h80, 1'b0, 32'h4, 32'h0);
      stop_case(8'h03, 8'h7F, 1'b0, 1'b0, 8'h80, 1'b0, 32'h1, 32'h0);
      stop_case(8'h09, 8'hFF, 1'b0, 1'b1, 8'h00, 1'b0, 32'h2, 32'h0);
      stop_case(8'h01, 8'h00, 1'b1, 1'b0, 8'h01, 1'b1, 32'h0, 32'h1);
      pin_reset();
      bus(1'b1, 32'h1C, 32'h1);
      src.drive(1'b1, 8'h00);
      q.push_back(32'h2);
      halt_pulse();
      src.drive(1'b0, 8'h00);
      rd(32'h48, 32'h0);
      repeat (5) @(posedge i_clk);
      results();
   end
   initial begin
      #1_000_000;
      err_count++;
      results();
   end
endmodule // testbench
